// >>> src/supply_cmd.sv
// Wishbone command block: trigger arming, output enable, setting storage
`timescale 1ns/1ns
module supply_cmd #(
   parameter int LEVEL_W = 16
) (
   input  wire logic               mclk_i,
   input  wire logic               reset_n_i,
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [7:0]         wb_adr_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic [31:0]        wb_dat_i,
   output logic      [31:0]        wb_dat_o,
   output logic                    wb_ack_o,
   input  wire logic [LEVEL_W-1:0] sense_volt_i,
   input  wire logic [LEVEL_W-1:0] sense_curr_i,
   input  wire logic [LEVEL_W-1:0] meas_tol_i,
   output logic      [LEVEL_W-1:0] prog_volt_o,
   output logic      [LEVEL_W-1:0] prog_curr_o,
   output logic      [LEVEL_W-1:0] volt_prot_o,
   output logic      [LEVEL_W-1:0] curr_prot_o,
   output logic                    drive_enable_o,
   output logic                    wait_trigger_flag_o
);
   // Setpoints and trigger state
   logic [LEVEL_W-1:0] set_volt;
   logic [LEVEL_W-1:0] set_curr;
   logic [LEVEL_W-1:0] pending_potential_level;
   logic [LEVEL_W-1:0] pending_amp_level;
   logic               continuous_arm;
   logic               single_arm;
   logic               drive_enable;
   logic               curr_mode;
   logic               remote;
   logic               cal_mode;
   logic [29:0]        config_live;
   logic [29:0]        nv_config;
   logic               nv_drive_en;
   logic               nv_curr_mode;
   logic               por_done;

   // Bus decode: single-cycle ack, dropped after one cycle
   logic wr_go;
   logic rd_go;
   assign wr_go = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
   assign rd_go = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;

   // Command strobes decoded from a write to the command register
   logic cmd_wr;
   logic do_abort;
   logic do_init;
   logic do_trig;
   logic do_rst;
   logic do_reload;
   logic do_save;
   logic [2:0] save_grp;
   assign cmd_wr    = wr_go && wb_adr_i == supply_cmd_pkg::CMD_OFS && wb_sel_i[0];
   assign do_abort  = (cmd_wr && wb_dat_i[supply_cmd_pkg::CMD_ABORT]) || !por_done;
   assign do_init   = cmd_wr && wb_dat_i[supply_cmd_pkg::CMD_INIT];
   assign do_trig   = cmd_wr && wb_dat_i[supply_cmd_pkg::CMD_TRIGGER];
   assign do_rst    = cmd_wr && wb_dat_i[supply_cmd_pkg::CMD_RESET];
   assign do_reload = cmd_wr && wb_dat_i[supply_cmd_pkg::CMD_RELOAD];
   assign do_save   = cmd_wr && wb_dat_i[supply_cmd_pkg::CMD_SAVE] && wb_sel_i[1];
   assign save_grp  = wb_dat_i[supply_cmd_pkg::CMD_SAVE_GRP_LO +: 3];

   logic ctrl_wr;
   assign ctrl_wr = wr_go && wb_adr_i == supply_cmd_pkg::CTRL_OFS && wb_sel_i[0];

   // Armed means continuous or a single shot still outstanding
   logic armed;
   assign armed = continuous_arm || single_arm;
   logic trig_take;
   assign trig_take = do_trig && armed && !do_abort;

   // Byte-lane mask builder, used for the setpoint and pending-level words
   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction : lane_mask

   // Mask for one save group in the config word
   function automatic logic [29:0] grp_mask(input logic [2:0] grp);
      // Shift amount worked in int so group five does not wrap in three bits
      grp_mask = 30'(30'h1F << (int'(grp) * supply_cmd_pkg::GRP_WIDTH));
   endfunction : grp_mask

   // Power-on marker: first cycle after reset performs an abort
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         por_done <= 1'b0;
      end else begin
         por_done <= 1'b1;
      end
   end

   // Continuous arm setting
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         continuous_arm <= supply_cmd_pkg::CONT_ARM_RST;
      end else if (do_rst) begin
         continuous_arm <= 1'b1;
      end else if (ctrl_wr) begin
         continuous_arm <= wb_dat_i[supply_cmd_pkg::CTRL_CONT_ARM];
      end
   end

   // Single-shot arm: set by initiate, spent by a trigger, dropped by abort
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         single_arm <= 1'b0;
      end else if (do_abort) begin
         single_arm <= 1'b0;
      end else if (do_init && !continuous_arm) begin
         single_arm <= 1'b1;
      end else if (trig_take && !continuous_arm) begin
         single_arm <= 1'b0;
      end
   end

   // Pending trigger levels; abort resyncs them to the live setpoints
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         pending_potential_level <= '0;
         pending_amp_level       <= '0;
      end else if (do_abort) begin
         pending_potential_level <= set_volt;
         pending_amp_level       <= set_curr;
      end else if (wr_go) begin
         if (wb_adr_i == supply_cmd_pkg::TRIG_VOLT_OFS) begin
            pending_potential_level <= (pending_potential_level & ~LEVEL_W'(lane_mask(wb_sel_i)))
                                     | (LEVEL_W'(wb_dat_i) & LEVEL_W'(lane_mask(wb_sel_i)));
         end
         if (wb_adr_i == supply_cmd_pkg::TRIG_CURR_OFS) begin
            pending_amp_level <= (pending_amp_level & ~LEVEL_W'(lane_mask(wb_sel_i)))
                               | (LEVEL_W'(wb_dat_i) & LEVEL_W'(lane_mask(wb_sel_i)));
         end
      end
   end

   // Immediate setpoints: software writes, or trigger loads pending levels
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         set_volt <= '0;
         set_curr <= '0;
      end else if (trig_take) begin
         set_volt <= pending_potential_level;
         set_curr <= pending_amp_level;
      end else if (wr_go) begin
         if (wb_adr_i == supply_cmd_pkg::SET_VOLT_OFS) begin
            set_volt <= (set_volt & ~LEVEL_W'(lane_mask(wb_sel_i)))
                      | (LEVEL_W'(wb_dat_i) & LEVEL_W'(lane_mask(wb_sel_i)));
         end
         if (wb_adr_i == supply_cmd_pkg::SET_CURR_OFS) begin
            set_curr <= (set_curr & ~LEVEL_W'(lane_mask(wb_sel_i)))
                      | (LEVEL_W'(wb_dat_i) & LEVEL_W'(lane_mask(wb_sel_i)));
         end
      end
   end

   // Output enable, mode, remote and calibration bits
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         drive_enable <= supply_cmd_pkg::DRIVE_EN_RST;
         curr_mode    <= 1'b0;
         remote       <= 1'b0;
         cal_mode     <= 1'b0;
      end else if (do_reload) begin
         drive_enable <= nv_drive_en;
         curr_mode    <= nv_curr_mode;
      end else if (ctrl_wr) begin
         drive_enable <= wb_dat_i[supply_cmd_pkg::CTRL_DRIVE_EN];
         curr_mode    <= wb_dat_i[supply_cmd_pkg::CTRL_CURR_MODE];
         remote       <= wb_dat_i[supply_cmd_pkg::CTRL_REMOTE];
         cal_mode     <= wb_dat_i[supply_cmd_pkg::CTRL_CAL];
      end
   end

   // Live and stored setting groups; reset clears both, stored copy reaches live only on reload
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         config_live <= '0;
         nv_config   <= '0;
         nv_drive_en <= supply_cmd_pkg::DRIVE_EN_RST;
         nv_curr_mode <= 1'b0;
      end else begin
         if (do_reload) begin
            config_live <= nv_config;
         end else if (wr_go && wb_adr_i == supply_cmd_pkg::CONFIG_OFS) begin
            config_live <= 30'(wb_dat_i);
         end
         if (do_save && save_grp <= supply_cmd_pkg::GRP_OUTPUT) begin
            nv_config <= (nv_config & ~grp_mask(save_grp))
                       | (config_live & grp_mask(save_grp));
         end
         if (do_save && save_grp == supply_cmd_pkg::GRP_OUTPUT) begin
            nv_drive_en  <= drive_enable;
            nv_curr_mode <= curr_mode;
         end
      end
   end

   // Output stage: while disabled, the mode's level is zero, guard low
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         prog_volt_o <= '0;
         prog_curr_o <= '0;
         volt_prot_o <= '1;
         curr_prot_o <= '1;
      end else if (drive_enable) begin
         prog_volt_o <= set_volt;
         prog_curr_o <= set_curr;
         volt_prot_o <= '1;
         curr_prot_o <= '1;
      end else if (curr_mode) begin
         prog_volt_o <= set_volt;
         prog_curr_o <= '0;
         volt_prot_o <= LEVEL_W'(supply_cmd_pkg::PROT_LOW);
         curr_prot_o <= '1;
      end else begin
         prog_volt_o <= '0;
         prog_curr_o <= set_curr;
         volt_prot_o <= '1;
         curr_prot_o <= LEVEL_W'(supply_cmd_pkg::PROT_LOW);
      end
   end

   // Status outputs
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         drive_enable_o      <= supply_cmd_pkg::DRIVE_EN_RST;
         wait_trigger_flag_o <= 1'b0;
      end else begin
         drive_enable_o      <= drive_enable;
         wait_trigger_flag_o <= armed;
      end
   end

   // Tag numeric replies with the scientific-notation format marker
   function automatic logic [31:0] num_reply(input logic [LEVEL_W-1:0] v);
      num_reply = 32'(v);
      num_reply[supply_cmd_pkg::SCI_FMT_BIT] = 1'b1;
   endfunction : num_reply

   // Read mux, unmapped reads return zero
   logic [31:0] rd_word;
   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (wb_adr_i)
         supply_cmd_pkg::CTRL_OFS: begin
            rd_word[supply_cmd_pkg::CTRL_CONT_ARM]  = continuous_arm;
            rd_word[supply_cmd_pkg::CTRL_DRIVE_EN]  = drive_enable;
            rd_word[supply_cmd_pkg::CTRL_CURR_MODE] = curr_mode;
            rd_word[supply_cmd_pkg::CTRL_REMOTE]    = remote;
            rd_word[supply_cmd_pkg::CTRL_CAL]       = cal_mode;
         end
         supply_cmd_pkg::SET_VOLT_OFS:  rd_word = num_reply(set_volt);
         supply_cmd_pkg::SET_CURR_OFS:  rd_word = num_reply(set_curr);
         supply_cmd_pkg::TRIG_VOLT_OFS: rd_word = num_reply(pending_potential_level);
         supply_cmd_pkg::TRIG_CURR_OFS: rd_word = num_reply(pending_amp_level);
         supply_cmd_pkg::OPER_COND_OFS: rd_word[supply_cmd_pkg::WAIT_TRIG_BIT] = armed;
         supply_cmd_pkg::MEAS_VOLT_OFS: rd_word = num_reply(sense_volt_i);
         supply_cmd_pkg::MEAS_CURR_OFS: rd_word = num_reply(cal_mode ? meas_tol_i : sense_curr_i);
         supply_cmd_pkg::PROG_VOLT_OFS: rd_word = num_reply(prog_volt_o);
         supply_cmd_pkg::PROG_CURR_OFS: rd_word = num_reply(prog_curr_o);
         supply_cmd_pkg::SAVED_OFS:     rd_word = {30'h0, nv_curr_mode, nv_drive_en};
         supply_cmd_pkg::CONFIG_OFS:    rd_word = {2'b00, config_live};
         supply_cmd_pkg::NV_CONFIG_OFS: rd_word = {2'b00, nv_config};
         default:                       rd_word = 32'h0000_0000;
      endcase
   end

   // Ack every request (mapped or not) one cycle after it appears
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wr_go || rd_go;
         wb_dat_o <= rd_go ? rd_word : 32'h0000_0000;
      end
   end

   // Assertions
   property p_abort_clears;
      @(posedge mclk_i) disable iff (!reset_n_i)
         (cmd_wr && wb_dat_i[supply_cmd_pkg::CMD_ABORT] && !continuous_arm && !do_rst) |=> ##1 !wait_trigger_flag_o;
   endproperty
   a_abort_clears: assert property (p_abort_clears) else $error("abort left wait flag set");

   property p_abort_copies;
      @(posedge mclk_i) disable iff (!reset_n_i)
         do_abort |=> (pending_potential_level == $past(set_volt) && pending_amp_level == $past(set_curr));
   endproperty
   a_abort_copies: assert property (p_abort_copies) else $error("abort did not copy setpoints");

   property p_cont_rearm;
      @(posedge mclk_i) disable iff (!reset_n_i)
         (do_abort && continuous_arm && !ctrl_wr) |=> ##1 wait_trigger_flag_o;
   endproperty
   a_cont_rearm: assert property (p_cont_rearm) else $error("continuous arm did not re-arm");

   property p_init_arms;
      @(posedge mclk_i) disable iff (!reset_n_i)
         (do_init && !do_abort) |=> ##1 wait_trigger_flag_o;
   endproperty
   a_init_arms: assert property (p_init_arms) else $error("initiate did not arm");

   property p_trig_loads;
      @(posedge mclk_i) disable iff (!reset_n_i)
         trig_take |=> (set_volt == $past(pending_potential_level) && set_curr == $past(pending_amp_level));
   endproperty
   a_trig_loads: assert property (p_trig_loads) else $error("trigger did not load levels");

   property p_trig_ignored;
      @(posedge mclk_i) disable iff (!reset_n_i)
         (do_trig && !armed && !do_abort) |=> $stable(set_volt);
   endproperty
   a_trig_ignored: assert property (p_trig_ignored) else $error("unarmed trigger changed setpoint");

   property p_single_spent;
      @(posedge mclk_i) disable iff (!reset_n_i)
         (trig_take && !continuous_arm && !do_init && !do_rst) |=> !single_arm ##1 !wait_trigger_flag_o;
   endproperty
   a_single_spent: assert property (p_single_spent) else $error("single arm not spent");

   property p_rst_cont;
      @(posedge mclk_i) disable iff (!reset_n_i)
         do_rst |=> continuous_arm;
   endproperty
   a_rst_cont: assert property (p_rst_cont) else $error("reset command left continuous off");

   property p_off_zero;
      @(posedge mclk_i) disable iff (!reset_n_i)
         (!drive_enable && !curr_mode) |=> (prog_volt_o == '0 && curr_prot_o == LEVEL_W'(supply_cmd_pkg::PROT_LOW));
   endproperty
   a_off_zero: assert property (p_off_zero) else $error("disabled voltage mode not zeroed");

   property p_on_restore;
      @(posedge mclk_i) disable iff (!reset_n_i)
         drive_enable |=> (prog_volt_o == $past(set_volt) && prog_curr_o == $past(set_curr));
   endproperty
   a_on_restore: assert property (p_on_restore) else $error("enabled output not restored");
endmodule : supply_cmd

// >>> src/supply_cmd_pkg.sv
// Constants and register map for the supply command block
// What this block does
// - Abort discards pending trigger levels
// - Abort copies immediate setpoints into pending levels
// - Abort clears wait flag, status bit five
// - Continuous arm re-arms right after abort
// - Abort action runs at every power-on
// - Initiate arms for exactly one trigger
// - Armed trigger loads setpoints from pending levels
// - Later triggers ignored until re-armed
// - Continuous arm keeps armed; initiate redundant
// - Reset command turns continuous arm on
// - Continuous arm query returns one or zero
// - Voltage measure returns sensed output voltage
// - Current measure returns tolerance during calibration
// - Reload restores saved variables from storage
// - Save interface or reference setting groups
// - Save serial, limits, display or output groups
// - Output off saves levels, zeroes per mode
// - Output on restores saved levels; queries show them
// - Power-up output enabled; remote leaves it alone
// - Output query returns zero or one
// - Operation status holds wait flag while armed
// - Numeric replies carry scientific notation format
package supply_cmd_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFS      = 8'h00;
   localparam logic [7:0] CMD_OFS       = 8'h04;
   localparam logic [7:0] SET_VOLT_OFS  = 8'h08;
   localparam logic [7:0] SET_CURR_OFS  = 8'h0C;
   localparam logic [7:0] TRIG_VOLT_OFS = 8'h10;
   localparam logic [7:0] TRIG_CURR_OFS = 8'h14;
   localparam logic [7:0] OPER_COND_OFS = 8'h18;
   localparam logic [7:0] MEAS_VOLT_OFS = 8'h1C;
   localparam logic [7:0] MEAS_CURR_OFS = 8'h20;
   localparam logic [7:0] PROG_VOLT_OFS = 8'h24;
   localparam logic [7:0] PROG_CURR_OFS = 8'h28;
   localparam logic [7:0] SAVED_OFS     = 8'h2C;
   localparam logic [7:0] CONFIG_OFS    = 8'h30;
   localparam logic [7:0] NV_CONFIG_OFS = 8'h34;
   // Command register bit positions (write one to execute)
   localparam int CMD_ABORT      = 0;
   localparam int CMD_INIT       = 1;
   localparam int CMD_TRIGGER    = 2;
   localparam int CMD_RESET      = 3;
   localparam int CMD_RELOAD     = 4;
   localparam int CMD_SAVE       = 5;
   localparam int CMD_SAVE_GRP_LO = 8;
   // Control register bit positions
   localparam int CTRL_CONT_ARM  = 0;
   localparam int CTRL_DRIVE_EN  = 1;
   localparam int CTRL_CURR_MODE = 2;
   localparam int CTRL_REMOTE    = 3;
   localparam int CTRL_CAL       = 4;
   // Wait-for-trigger flag in the operation condition register
   localparam int WAIT_TRIG_BIT  = 5;
   // Format tag bit on numeric replies: scientific notation
   localparam int SCI_FMT_BIT    = 31;
   // Save groups, five bits each within the config word
   localparam logic [2:0] GRP_INTERFACE = 3'h0;
   localparam logic [2:0] GRP_REFERENCE = 3'h1;
   localparam logic [2:0] GRP_LIMITS    = 3'h2;
   localparam logic [2:0] GRP_SERIAL    = 3'h3;
   localparam logic [2:0] GRP_CONTRAST  = 3'h4;
   localparam logic [2:0] GRP_OUTPUT    = 3'h5;
   localparam int GRP_WIDTH = 5;
   // Reset values, and the guard level driven while the output is disabled
   localparam logic        CONT_ARM_RST  = 1'b1;
   localparam logic        DRIVE_EN_RST  = 1'b1;
   localparam logic [15:0] PROT_LOW      = 16'h0001;
endpackage : supply_cmd_pkg

// >>> verification/host_ctrl_model.sv
// Host controller model: classic Wishbone master driving the command block
`timescale 1ns/1ns
module host_ctrl_model (
   input  wire logic        mclk_i,
   input  wire logic        ack_i,
   input  wire logic [31:0] dat_i,
   output logic             cyc_o,
   output logic             stb_o,
   output logic             we_o,
   output logic [7:0]       adr_o,
   output logic [3:0]       sel_o,
   output logic [31:0]      dat_o
);
   // Idle bus at time zero
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o  = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'h0;
      dat_o = 32'h0000_0000;
   end

   // One classic cycle; waits for ack with no bound, the bench watchdog cuts hangs
   task xfer(input logic we, input logic [7:0] adr, input logic [31:0] wdat, output logic [31:0] rdat);
      @(posedge mclk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o  <= we;
      adr_o <= adr;
      sel_o <= 4'hf;
      dat_o <= wdat;
      do @(posedge mclk_i); while (ack_i !== 1'b1);
      rdat = dat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      // Released lines show a changed pattern so stale data never looks valid
      adr_o <= ~adr;
      dat_o <= ~wdat;
   endtask : xfer

   // Active load: keep output on, go to current mode and program zero current
   task quiesce_active_load(input logic [31:0] ctrl_word);
      logic [31:0] tmp;
      xfer(1'b1, supply_cmd_pkg::CTRL_OFS, ctrl_word | 32'h0000_0004, tmp);
      xfer(1'b1, supply_cmd_pkg::SET_CURR_OFS, 32'h0000_0000, tmp);
   endtask : quiesce_active_load
endmodule : host_ctrl_model

// >>> verification/test_supply_cmd.sv
// Self-checking bench for the supply command block
`timescale 1ns/1ns
module test_supply_cmd;
   logic        mclk_i;
   logic        reset_n_i;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic        ack;
   logic [15:0] sense_volt;
   logic [15:0] sense_curr;
   logic [15:0] meas_tol;
   logic [15:0] prog_volt;
   logic [15:0] prog_curr;
   logic [15:0] volt_prot;
   logic [15:0] curr_prot;
   logic        drive_enable;
   logic        wait_flag;
   int          fail_count;
   int          n_checks;
   logic [4:0]  ctl;
   logic [31:0] d;
   logic [31:0] r;
   logic [15:0] v;
   logic [15:0] c;
   logic [15:0] pv;
   logic [15:0] pc;

   supply_cmd dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .sense_volt_i(sense_volt), .sense_curr_i(sense_curr), .meas_tol_i(meas_tol), .prog_volt_o(prog_volt),
      .prog_curr_o(prog_curr), .volt_prot_o(volt_prot), .curr_prot_o(curr_prot),
      .drive_enable_o(drive_enable), .wait_trigger_flag_o(wait_flag));

   host_ctrl_model host (.mclk_i(mclk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
      .adr_o(adr), .sel_o(sel), .dat_o(wdat));

   // 100 MHz clock
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task summarize;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize

   task wr(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] dummy;
      host.xfer(1'b1, a, x, dummy);
   endtask : wr

   task rd(input logic [7:0] a, output logic [31:0] x);
      host.xfer(1'b0, a, 32'h0000_0000, x);
   endtask : rd

   task cmd(input int b);
      wr(supply_cmd_pkg::CMD_OFS, 32'h0000_0001 << b);
   endtask : cmd

   // Control bits: cal, remote, current mode, drive enable, continuous arm
   task wctl(input logic [4:0] x);
      ctl = x;
      wr(supply_cmd_pkg::CTRL_OFS, {27'h0, x});
   endtask : wctl

   // Command lands at ack; outputs and flag lag up to two more edges
   task settle;
      repeat (3) @(posedge mclk_i);
   endtask : settle

   // Watchdog: the whole run needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge mclk_i);
      fail_count++;
      summarize();
   end

   initial begin
      fail_count = 0;
      n_checks = 0;
      reset_n_i = 1'b0;
      sense_volt = 16'h0000;
      sense_curr = 16'h0000;
      meas_tol = 16'h0000;
      void'($urandom(32'hdf7e));
      repeat (8) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      settle();
      // Power-on state
      chk("drive_enable", 1, drive_enable);
      chk("wait_flag", 1, wait_flag);
      rd(supply_cmd_pkg::OPER_COND_OFS, d);
      chk("oper_wait_bit", 1, d[supply_cmd_pkg::WAIT_TRIG_BIT]);
      rd(supply_cmd_pkg::CTRL_OFS, d);
      chk("ctrl_reset", 32'h0000_0003, d & 32'h0000_0003);
      rd(8'hfc, d);
      chk("unmapped", 0, d);
      $display("test power_on done");
      // Abort copies immediate levels into pending ones
      v = 16'($urandom);
      c = 16'($urandom);
      wr(supply_cmd_pkg::SET_VOLT_OFS, {16'h0, v});
      wr(supply_cmd_pkg::SET_CURR_OFS, {16'h0, c});
      wr(supply_cmd_pkg::TRIG_VOLT_OFS, {16'h0, ~v});
      cmd(supply_cmd_pkg::CMD_ABORT);
      rd(supply_cmd_pkg::TRIG_VOLT_OFS, d);
      chk("pending_volt", v, d[15:0]);
      rd(supply_cmd_pkg::TRIG_CURR_OFS, d);
      chk("pending_curr", c, d[15:0]);
      settle();
      chk("rearm", 1, wait_flag);
      $display("test abort done");
      // Single-shot arming with remote mode on
      wctl(5'b01010);
      settle();
      chk("remote_keeps_drive", 1, drive_enable);
      cmd(supply_cmd_pkg::CMD_ABORT);
      settle();
      chk("abort_clears", 0, wait_flag);
      rd(supply_cmd_pkg::CTRL_OFS, d);
      chk("cont_query_off", 0, d[0]);
      pv = 16'($urandom);
      pc = 16'($urandom);
      wr(supply_cmd_pkg::TRIG_VOLT_OFS, {16'h0, pv});
      wr(supply_cmd_pkg::TRIG_CURR_OFS, {16'h0, pc});
      cmd(supply_cmd_pkg::CMD_TRIGGER);
      settle();
      chk("unarmed_trigger", v, prog_volt);
      cmd(supply_cmd_pkg::CMD_INIT);
      settle();
      chk("init_arms", 1, wait_flag);
      cmd(supply_cmd_pkg::CMD_TRIGGER);
      settle();
      chk("trig_volt", pv, prog_volt);
      chk("trig_curr", pc, prog_curr);
      chk("trig_clears", 0, wait_flag);
      wr(supply_cmd_pkg::TRIG_VOLT_OFS, {16'h0, ~pv});
      cmd(supply_cmd_pkg::CMD_TRIGGER);
      settle();
      chk("second_trigger", pv, prog_volt);
      $display("test single_trigger done");
      // Reset command turns continuous arming back on
      cmd(supply_cmd_pkg::CMD_RESET);
      rd(supply_cmd_pkg::CTRL_OFS, d);
      chk("cont_query_on", 1, d[0]);
      ctl[0] = 1'b1;
      for (int i = 0; i < 3; i++) begin
         pv = 16'($urandom);
         wr(supply_cmd_pkg::TRIG_VOLT_OFS, {16'h0, pv});
         cmd(supply_cmd_pkg::CMD_TRIGGER);
         settle();
         chk("cont_trigger", pv, prog_volt);
         chk("cont_armed", 1, wait_flag);
      end
      cmd(supply_cmd_pkg::CMD_INIT);
      settle();
      chk("init_redundant", 1, wait_flag);
      $display("test continuous done");
      // Measurement queries, with and without calibration
      for (int i = 0; i < 4; i++) begin
         sense_volt <= 16'($urandom);
         sense_curr <= 16'($urandom);
         meas_tol <= 16'($urandom);
         wctl({i[0], ctl[3:0]});
         rd(supply_cmd_pkg::MEAS_VOLT_OFS, d);
         chk("meas_volt", {1'b1, 15'h0, sense_volt}, d & 32'h8000_ffff);
         rd(supply_cmd_pkg::MEAS_CURR_OFS, d);
         chk("meas_curr", {1'b1, 15'h0, i[0] ? meas_tol : sense_curr}, d & 32'h8000_ffff);
      end
      $display("test measure done");
      // Output off and on in both source modes
      for (int m = 0; m < 2; m++) begin
         wctl({2'b01, m[0], 1'b1, 1'b1});
         v = 16'($urandom);
         c = 16'($urandom);
         wr(supply_cmd_pkg::SET_VOLT_OFS, {16'h0, v});
         wr(supply_cmd_pkg::SET_CURR_OFS, {16'h0, c});
         wctl({2'b01, m[0], 1'b0, 1'b1});
         settle();
         chk("drive_off", 0, drive_enable);
         chk("zeroed", 0, m ? prog_curr : prog_volt);
         chk("prot_low", supply_cmd_pkg::PROT_LOW, m ? volt_prot : curr_prot);
         rd(supply_cmd_pkg::SET_VOLT_OFS, d);
         chk("saved_volt", v, d[15:0]);
         rd(supply_cmd_pkg::CTRL_OFS, d);
         chk("out_query", 0, d[1]);
         wctl({2'b01, m[0], 1'b1, 1'b1});
         settle();
         chk("restore_volt", v, prog_volt);
         chk("restore_curr", c, prog_curr);
      end
      host.quiesce_active_load({27'h0, ctl});
      settle();
      chk("active_zero_curr", 0, prog_curr);
      chk("active_drive_on", 1, drive_enable);
      $display("test output done");
      // Save each group, spoil live settings, reload
      for (int g = 0; g < 6; g++) begin
         r = $urandom & 32'h3fff_ffff;
         wr(supply_cmd_pkg::CONFIG_OFS, r);
         wr(supply_cmd_pkg::CMD_OFS, (32'h0000_0001 << supply_cmd_pkg::CMD_SAVE) | (g << 8));
         wr(supply_cmd_pkg::CONFIG_OFS, ~r & 32'h3fff_ffff);
         cmd(supply_cmd_pkg::CMD_RELOAD);
         rd(supply_cmd_pkg::CONFIG_OFS, d);
         chk("reloaded_group", (r >> (g * 5)) & 32'h1f, (d >> (g * 5)) & 32'h1f);
      end
      $display("test save_reload done");
      summarize();
   end
endmodule : test_supply_cmd
